// ===== dsc_pkg.sv
// Package with constants, types and helpers for the driver message block.
package dsc_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 8;
  localparam int DT_MAX_NS = 2000;
  localparam int DT_STEP_NS = 250;
  localparam int BLANK_MAX_NS = 4000;

  // ****************************************
  // Host command bytes
  // ****************************************
  localparam logic [7:0] CMD_REQ_A = 8'h85;
  localparam logic [7:0] CMD_REQ_B = 8'h86;
  localparam logic [7:0] CMD_SET_CFG = 8'h87;
  localparam logic [7:0] CMD_GET_CFG = 8'h88;

  // ****************************************
  // Message codes and kinds of first byte
  // ****************************************
  localparam logic [5:0] CODE_STAT_A = 6'h05;
  localparam logic [5:0] CODE_STAT_B = 6'h06;
  localparam logic [5:0] CODE_SET_CFG = 6'h07;
  localparam logic [5:0] CODE_GET_CFG = 6'h08;
  localparam logic [1:0] KIND_NACK = 2'h0;
  localparam logic [1:0] KIND_ACK = 2'h1;
  localparam logic [1:0] KIND_UNSOL = 2'h2;

  // ****************************************
  // Status and configuration fields
  // ****************************************
  localparam int B_GATE_UNDERVOLTAGE_LOCKOUT = 2;
  localparam int B_EXT_OC = 3;
  localparam int B_CFG_LOST = 4;
  localparam int B_LDO_UNDERVOLTAGE_LOCKOUT = 5;
  localparam logic [7:0] B_USED_MASK = 8'h3C;
  localparam logic [7:0] STAT_A_RESET = 8'h00;
  localparam logic [7:0] STAT_B_RESET = 8'h10;
  localparam logic [7:0] CFG_WRITE_MASK = 8'h1F;
  localparam logic [7:0] CFG_RESET = 8'h00;

  typedef struct packed {
    logic [2:0] rsvd;
    logic [2:0] dead;
    logic [1:0] blank;
  } dsc_cfg_t;

  typedef struct packed {
    logic [7:0] head;
    logic [7:0] body;
  } dsc_msg_t;

  typedef enum logic [0:0] {RX_CMD = 1'h0, RX_DATA = 1'h1} dsc_rx_t;
  typedef enum logic [1:0] {TX_IDLE = 2'h0, TX_HEAD = 2'h1, TX_BODY = 2'h2} dsc_tx_t;

  function automatic logic [7:0] dsc_head(input logic [1:0] kind, input logic [5:0] code);
    return {kind, code};
  endfunction

  function automatic logic [7:0] dsc_dead_cycles(input logic [2:0] code);
    return 8'((DT_MAX_NS - int'(code) * DT_STEP_NS) / CLK_PERIOD_NS);
  endfunction

  function automatic logic [8:0] dsc_blank_cycles(input logic [1:0] code);
    return 9'(((BLANK_MAX_NS >> code) + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  endfunction

endpackage

// ===== dsc_dead_gate.sv
// One half-bridge gate pair with dead-time insertion.
`timescale 1ns/1ns
module dsc_dead_gate (
  input wire logic clk,
  input wire logic reset,
  input wire logic pwm_high,
  input wire logic pwm_low,
  input wire logic [7:0] dead_cycles,
  output logic gate_high,
  output logic gate_low
);
  logic [7:0] gap;
  wire want_high = pwm_high & ~pwm_low;
  wire want_low = pwm_low & ~pwm_high;
  // Turn-on waits on the live gap count, so a new dead time applies at once.
  wire gap_done = (gap >= dead_cycles);
  wire next_gate_high = want_high & (gate_high | (~gate_low & gap_done));
  wire next_gate_low = want_low & (gate_low | (~gate_high & gap_done));
  wire [7:0] next_gap = (gate_high | gate_low) ? 8'h00 :
                        (gap == 8'hFF) ? gap : gap + 8'h01;

  // Both sides low for the dead time before either side turns on.
  always_ff @(posedge clk) begin
    if (reset) begin
      gate_high <= 1'b0;
      gate_low <= 1'b0;
      gap <= 8'hFF;
    end else begin
      gate_high <= next_gate_high;
      gate_low <= next_gate_low;
      gap <= next_gap;
    end
  end

  a_dead_gap_held: assert property (@(posedge clk) disable iff (reset)
    ($rose(gate_high) || $rose(gate_low)) |-> gap >= $past(dead_cycles))
    else $error("Gate turned on before dead time elapsed.");

  a_no_overlap: assert property (@(posedge clk) disable iff (reset)
    !(gate_high && gate_low))
    else $error("Both gates of one pair are on.");
endmodule // dsc_dead_gate

// ===== dsc_blank.sv
// Blanking of the overcurrent comparator after any gate turns on.
`timescale 1ns/1ns
module dsc_blank (
  input wire logic clk,
  input wire logic reset,
  input wire logic [5:0] gates,
  input wire logic oc_raw,
  input wire logic [8:0] blank_cycles,
  output logic oc_event
);
  logic [5:0] gates_q;
  logic [8:0] cnt;
  wire gate_rise = |(gates & ~gates_q);
  wire [8:0] next_cnt = gate_rise ? blank_cycles :
                        (cnt != 9'h000) ? cnt - 9'h001 : 9'h000;

  // Switching spikes inside the window never reach the fault flag.
  always_ff @(posedge clk) begin
    if (reset) begin
      gates_q <= 6'h00;
      cnt <= 9'h000;
      oc_event <= 1'b0;
    end else begin
      gates_q <= gates;
      cnt <= next_cnt;
      oc_event <= oc_raw & ~gate_rise & (cnt == 9'h000);
    end
  end

  a_blank_masks: assert property (@(posedge clk) disable iff (reset)
    gate_rise |=> !oc_event)
    else $error("Overcurrent passed at the start of blanking.");
endmodule // dsc_blank

// ===== dsc_driver_msg.sv
// Status report and timing configuration messages of the gate driver link.
//
// Contract
// - Status A response head 05H nack, 45H ack.
// - Status A unsolicited head is 85H.
// - Status A bit 0 temperature warning.
// - Status A bit 1 overtemperature.
// - Status A bit 2 input undervoltage.
// - Status A bit 3 driver supply overvoltage.
// - Status A bit 4 input overvoltage.
// - Bits 5, 6 regulator overcurrent, low output.
// - Status A bit 7 regulator brown-out error.
// - Status B response head 06H nack, 46H ack.
// - Status B unsolicited head is 86H.
// - Status B bit 2 gate supply lockout.
// - Status B bit 3 external transistor overcurrent.
// - Status B bit 4 configuration lost, set at start.
// - Status B bit 5 regulator lockout, others reserved.
// - Write configuration answer 07H nack, 47H ack.
// - Read configuration answer 08H/48H plus fields.
// - Bits 4:2 dead time, 2000 down 250 ns.
// - Bits 1:0 blanking time 4, 2, 1, 0.5 us.
`timescale 1ns/1ns
module dsc_driver_msg (
  input wire logic clk,
  input wire logic reset,
  input wire logic rx_valid,
  input wire logic [7:0] rx_byte,
  input wire logic rx_error,
  output logic rx_ready,
  output logic tx_valid,
  output logic [7:0] tx_byte,
  input wire logic tx_ready,
  input wire logic [7:0] fault_a_in,
  input wire logic gate_undervoltage_lockout_in,
  input wire logic low_dropout_regulator_undervoltage_lockout_in,
  input wire logic brownout_reset_in,
  input wire logic oc_compare_in,
  input wire logic [2:0] high_side_pwm_input,
  input wire logic [2:0] low_side_pwm_input,
  output logic [2:0] gate_high,
  output logic [2:0] gate_low
);

  // ****************************************
  // State
  // ****************************************
  dsc_pkg::dsc_cfg_t cfg;
  logic [7:0] stat_a;
  logic [7:0] stat_b;
  logic unsol_a;
  logic unsol_b;
  logic resp_valid;
  dsc_pkg::dsc_msg_t resp;
  dsc_pkg::dsc_msg_t msg;
  dsc_pkg::dsc_rx_t rx_state;
  dsc_pkg::dsc_tx_t tx_state;
  logic ext_oc;

  // ****************************************
  // Status capture
  // ****************************************
  // Fault A bits map one to one onto the status A byte.
  wire [7:0] src_a = fault_a_in;
  wire [7:0] src_b_raw = (8'({gate_undervoltage_lockout_in}) << dsc_pkg::B_GATE_UNDERVOLTAGE_LOCKOUT)
                       | (8'({ext_oc}) << dsc_pkg::B_EXT_OC)
                       | (8'({brownout_reset_in}) << dsc_pkg::B_CFG_LOST)
                       | (8'({low_dropout_regulator_undervoltage_lockout_in})
                          << dsc_pkg::B_LDO_UNDERVOLTAGE_LOCKOUT);
  wire [7:0] src_b = src_b_raw & dsc_pkg::B_USED_MASK;

  // ****************************************
  // Receive decode
  // ****************************************
  wire accept = rx_valid & rx_ready;
  wire in_cmd = (rx_state == dsc_pkg::RX_CMD);
  wire is_req_a = in_cmd & (rx_byte == dsc_pkg::CMD_REQ_A);
  wire is_req_b = in_cmd & (rx_byte == dsc_pkg::CMD_REQ_B);
  wire is_get = in_cmd & (rx_byte == dsc_pkg::CMD_GET_CFG);
  wire is_set = in_cmd & (rx_byte == dsc_pkg::CMD_SET_CFG);
  wire [1:0] kind = rx_error ? dsc_pkg::KIND_NACK : dsc_pkg::KIND_ACK;
  wire cfg_wr = accept & ~in_cmd & ~rx_error;
  wire dec_valid = accept & (~in_cmd | is_req_a | is_req_b | is_get | (is_set & rx_error));
  wire clr_a = accept & is_req_a & ~rx_error;
  wire clr_b = accept & is_req_b & ~rx_error;
  wire [7:0] wr_cfg = rx_byte & dsc_pkg::CFG_WRITE_MASK;

  wire [7:0] dec_head = ~in_cmd ? dsc_pkg::dsc_head(kind, dsc_pkg::CODE_SET_CFG) :
                        is_req_a ? dsc_pkg::dsc_head(kind, dsc_pkg::CODE_STAT_A) :
                        is_req_b ? dsc_pkg::dsc_head(kind, dsc_pkg::CODE_STAT_B) :
                        is_get ? dsc_pkg::dsc_head(kind, dsc_pkg::CODE_GET_CFG) :
                        dsc_pkg::dsc_head(dsc_pkg::KIND_NACK, dsc_pkg::CODE_SET_CFG);
  wire [7:0] dec_body = cfg_wr ? wr_cfg :
                        is_req_a ? stat_a :
                        is_req_b ? stat_b : cfg;
  wire dsc_pkg::dsc_msg_t dec_msg = {dec_head, dec_body};

  wire dsc_pkg::dsc_rx_t next_rx_state =
    (accept & is_set & ~rx_error) ? dsc_pkg::RX_DATA :
    (accept & ~in_cmd) ? dsc_pkg::RX_CMD : rx_state;

  // ****************************************
  // Transmit selection
  // ****************************************
  wire tx_idle = (tx_state == dsc_pkg::TX_IDLE);
  wire take_resp = tx_idle & resp_valid;
  wire take_a = tx_idle & ~resp_valid & unsol_a;
  wire take_b = tx_idle & ~resp_valid & ~unsol_a & unsol_b;
  wire load = take_resp | take_a | take_b;
  wire dsc_pkg::dsc_msg_t unsol_msg = take_a ?
    {dsc_pkg::dsc_head(dsc_pkg::KIND_UNSOL, dsc_pkg::CODE_STAT_A), stat_a} :
    {dsc_pkg::dsc_head(dsc_pkg::KIND_UNSOL, dsc_pkg::CODE_STAT_B), stat_b};
  wire dsc_pkg::dsc_msg_t next_msg = take_resp ? resp : unsol_msg;

  // Sticky flags: a new fault wins over a clear in the same cycle.
  wire [7:0] next_stat_a = src_a | (stat_a & ~{8{clr_a}});
  wire [7:0] next_stat_b = src_b | (stat_b & ~{8{clr_b}});
  wire new_a = |(src_a & ~stat_a);
  wire new_b = |(src_b & ~stat_b);
  wire next_unsol_a = new_a | (unsol_a & ~take_a);
  wire next_unsol_b = new_b | (unsol_b & ~take_b);
  wire next_resp_valid = dec_valid | (resp_valid & ~take_resp);

  wire dsc_pkg::dsc_cfg_t next_cfg = brownout_reset_in ? dsc_pkg::dsc_cfg_t'(dsc_pkg::CFG_RESET) :
                                     cfg_wr ? dsc_pkg::dsc_cfg_t'(wr_cfg) : cfg;

  dsc_pkg::dsc_tx_t next_tx_state;
  logic next_tx_valid;
  logic [7:0] next_tx_byte;

  always_comb begin
    next_tx_state = tx_state;
    next_tx_valid = tx_valid;
    next_tx_byte = tx_byte;
    case (tx_state)
      dsc_pkg::TX_IDLE: begin
        if (load) begin
          next_tx_state = dsc_pkg::TX_HEAD;
          next_tx_valid = 1'b1;
          next_tx_byte = next_msg.head;
        end
      end
      dsc_pkg::TX_HEAD: begin
        if (tx_ready) begin
          next_tx_state = dsc_pkg::TX_BODY;
          next_tx_byte = msg.body;
        end
      end
      dsc_pkg::TX_BODY: begin
        if (tx_ready) begin
          next_tx_state = dsc_pkg::TX_IDLE;
          next_tx_valid = 1'b0;
          next_tx_byte = 8'h00;
        end
      end
      default: begin
        next_tx_state = dsc_pkg::TX_IDLE;
        next_tx_valid = 1'b0;
        next_tx_byte = 8'h00;
      end
    endcase
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clk) begin
    if (reset) begin
      cfg <= dsc_pkg::dsc_cfg_t'(dsc_pkg::CFG_RESET);
      stat_a <= dsc_pkg::STAT_A_RESET;
      stat_b <= dsc_pkg::STAT_B_RESET;
      unsol_a <= 1'b0;
      unsol_b <= 1'b0;
      resp_valid <= 1'b0;
      resp <= '0;
      msg <= '0;
      rx_state <= dsc_pkg::RX_CMD;
      tx_state <= dsc_pkg::TX_IDLE;
      rx_ready <= 1'b0;
      tx_valid <= 1'b0;
      tx_byte <= 8'h00;
    end else begin
      cfg <= next_cfg;
      stat_a <= next_stat_a;
      stat_b <= next_stat_b;
      unsol_a <= next_unsol_a;
      unsol_b <= next_unsol_b;
      resp_valid <= next_resp_valid;
      resp <= dec_valid ? dec_msg : resp;
      msg <= load ? next_msg : msg;
      rx_state <= next_rx_state;
      tx_state <= next_tx_state;
      rx_ready <= ~next_resp_valid;
      tx_valid <= next_tx_valid;
      tx_byte <= next_tx_byte;
    end
  end

  // ****************************************
  // Gate drive and blanking
  // ****************************************
  wire [7:0] dead_cycles = dsc_pkg::dsc_dead_cycles(cfg.dead);
  wire [8:0] blank_cycles = dsc_pkg::dsc_blank_cycles(cfg.blank);

  for (genvar i = 0; i < 3; i++) begin : g_phase
    dsc_dead_gate u_gate (
      .clk(clk),
      .reset(reset),
      .pwm_high(high_side_pwm_input[i]),
      .pwm_low(low_side_pwm_input[i]),
      .dead_cycles(dead_cycles),
      .gate_high(gate_high[i]),
      .gate_low(gate_low[i])
    );
  end

  dsc_blank u_blank (
    .clk(clk),
    .reset(reset),
    .gates({gate_high, gate_low}),
    .oc_raw(oc_compare_in),
    .blank_cycles(blank_cycles),
    .oc_event(ext_oc)
  );

  // ****************************************
  // Checks
  // ****************************************
  sequence s_head_taken;
    tx_valid && tx_ready && tx_state == dsc_pkg::TX_HEAD;
  endsequence

  sequence s_body_taken;
    tx_valid && tx_ready && tx_state == dsc_pkg::TX_BODY;
  endsequence

  a_req_a_answer: assert property (@(posedge clk) disable iff (reset)
    accept && is_req_a |=> resp_valid &&
      resp.head == ($past(rx_error) ? 8'h05 : 8'h45) && resp.body == $past(stat_a))
    else $error("Status A answer head or body wrong.");

  a_req_b_answer: assert property (@(posedge clk) disable iff (reset)
    accept && is_req_b |=> resp.head == ($past(rx_error) ? 8'h06 : 8'h46))
    else $error("Status B answer head wrong.");

  a_unsol_head: assert property (@(posedge clk) disable iff (reset)
    take_a || take_b |=> tx_valid && tx_byte == ($past(take_a) ? 8'h85 : 8'h86))
    else $error("Unsolicited report head wrong.");

  a_new_fault_flags: assert property (@(posedge clk) disable iff (reset)
    new_a |=> unsol_a ##0 (stat_a & $past(src_a)) == $past(src_a))
    else $error("New fault did not raise a report.");

  a_stat_b_reserved: assert property (@(posedge clk) disable iff (reset)
    (stat_b & ~dsc_pkg::B_USED_MASK) == 8'h00)
    else $error("Reserved status B bit set.");

  a_cfg_lost_start: assert property (@(posedge clk)
    $fell(reset) |-> stat_b[dsc_pkg::B_CFG_LOST])
    else $error("Configuration lost flag clear after start.");

  a_set_cfg_write: assert property (@(posedge clk) disable iff (reset)
    cfg_wr && !brownout_reset_in |=> cfg == ($past(rx_byte) & 8'h1F) && resp.head == 8'h47)
    else $error("Configuration write not stored or acknowledged.");

  a_get_cfg_body: assert property (@(posedge clk) disable iff (reset)
    accept && is_get && !rx_error |=> resp == {8'h48, $past(cfg)})
    else $error("Configuration read answer wrong.");

  a_cfg_reserved: assert property (@(posedge clk) disable iff (reset)
    cfg.rsvd == 3'h0)
    else $error("Reserved configuration bits not zero.");

  a_msg_body_next: assert property (@(posedge clk) disable iff (reset)
    s_head_taken |=> tx_valid && tx_state == dsc_pkg::TX_BODY && tx_byte == msg.body)
    else $error("Message body did not follow head.");

  a_msg_end_idle: assert property (@(posedge clk) disable iff (reset)
    s_body_taken |=> !tx_valid)
    else $error("Link not released after message body.");

  a_set_nack_keeps: assert property (@(posedge clk) disable iff (reset)
    accept && !in_cmd && rx_error && !brownout_reset_in |=>
      cfg == $past(cfg) && resp.head == 8'h07)
    else $error("Refused configuration write changed the register.");

  a_get_nack_answer: assert property (@(posedge clk) disable iff (reset)
    accept && is_get && rx_error |=> resp == {8'h08, $past(cfg)})
    else $error("Refused configuration read answer wrong.");

  a_ack_a_clears: assert property (@(posedge clk) disable iff (reset)
    clr_a |=> stat_a == $past(src_a))
    else $error("Acknowledged status A request did not clear flags.");

  a_ack_b_clears: assert property (@(posedge clk) disable iff (reset)
    clr_b |=> stat_b == $past(src_b))
    else $error("Acknowledged status B request did not clear flags.");

  a_nack_keeps_a: assert property (@(posedge clk) disable iff (reset)
    accept && is_req_a && rx_error |=> stat_a == ($past(stat_a) | $past(src_a)))
    else $error("Refused status A request cleared flags.");

endmodule // dsc_driver_msg

// ===== dsc_host.sv
// Host controller model on the driver message link.
`timescale 1ns/1ns
module dsc_host (
  input wire logic clk,
  input wire logic rx_ready,
  input wire logic tx_valid,
  input wire logic [7:0] tx_byte,
  input wire logic slow,
  output logic rx_valid,
  output logic [7:0] rx_byte,
  output logic rx_error,
  output logic tx_ready
);
  integer seed = 44;
  logic [7:0] got[$];
  initial begin
    rx_valid = 1'b0;
    rx_byte = 8'h00;
    rx_error = 1'b0;
    tx_ready = 1'b1;
  end
  // A released byte line shows the inverse so stale data cannot pass.
  task automatic send(input logic [7:0] b, input logic err);
    @(negedge clk);
    rx_valid = 1'b1;
    rx_byte = b;
    rx_error = err;
    while (rx_ready !== 1'b1) @(negedge clk);
    @(negedge clk);
    rx_valid = 1'b0;
    rx_byte = ~b;
    rx_error = 1'b0;
  endtask
  always @(negedge clk) tx_ready <= slow ? 1'($random(seed)) : 1'b1;
  always @(posedge clk) begin
    if (tx_valid === 1'b1 && tx_ready === 1'b1) got.push_back(tx_byte);
  end
endmodule // dsc_host

// ===== test_driver_status_config_messages.sv
// Self-checking bench for the driver message block.
`timescale 1ns/1ns
module test_driver_status_config_messages;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic rx_valid, rx_error, rx_ready, tx_valid, tx_ready, slow = 1'b0;
  logic [7:0] rx_byte, tx_byte, v;
  logic [7:0] fault_a_in = 8'h00;
  logic [3:0] fb = 4'h0;
  logic [2:0] hi = 3'h0, lo = 3'h0, gate_high, gate_low;
  integer mismatches = 0, n_tests = 0, seed = 44, cycles = 0, gap, ex;
  int sa = 0, sb = 16, cfg = 0;
  always #4 clk = ~clk;
  dsc_driver_msg u_dut (.clk(clk), .reset(reset), .rx_valid(rx_valid), .rx_byte(rx_byte),
    .rx_error(rx_error), .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_byte(tx_byte),
    .tx_ready(tx_ready), .fault_a_in(fault_a_in), .gate_undervoltage_lockout_in(fb[3]),
    .low_dropout_regulator_undervoltage_lockout_in(fb[2]), .brownout_reset_in(fb[1]),
    .oc_compare_in(fb[0]), .high_side_pwm_input(hi), .low_side_pwm_input(lo),
    .gate_high(gate_high), .gate_low(gate_low));
  dsc_host u_host (.clk(clk), .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_byte(tx_byte),
    .slow(slow), .rx_valid(rx_valid), .rx_byte(rx_byte), .rx_error(rx_error),
    .tx_ready(tx_ready));
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Waits for one whole message; a missing one compares as unknown.
  task automatic expect_msg(input logic [7:0] h, input logic [7:0] b);
    int w;
    w = 0;
    while (u_host.got.size() < 2 && w < 600) begin
      @(negedge clk);
      w++;
    end
    if (u_host.got.size() < 2) u_host.got = {8'hXX, 8'hXX};
    check(u_host.got.pop_front(), h);
    check(u_host.got.pop_front(), b);
  endtask
  task automatic req(input logic [7:0] c, input logic err, input logic [7:0] h, input int b);
    u_host.send(c, err);
    expect_msg(h, 8'(b));
  endtask
  task automatic pulse_b(input logic [3:0] p);
    fb = p;
    repeat (2) @(negedge clk);
    fb = 4'h0;
  endtask
  task automatic conclude();
    $display("Counts: %0d compared, %0d mismatched", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      mismatches++;
      $display("Error at %0t: timeout", $time);
      conclude();
    end
  end
  initial begin
    repeat (10) @(negedge clk);
    reset = 1'b0;
    repeat (20) @(negedge clk);
    u_host.got.delete();
    req(8'h86, 1'b0, 8'h46, sb);
    sb = 0;
    req(8'h88, 1'b0, 8'h48, cfg);
    req(8'h85, 1'b0, 8'h45, sa);
    $display("Test reset values done");
    for (int n = 0; n < 9; n++) begin
      v = (n < 8) ? 8'h01 << n : 8'($random(seed)) | 8'h01;
      fault_a_in = v;
      repeat (2) @(negedge clk);
      fault_a_in = 8'h00;
      sa = v;
      expect_msg(8'h85, 8'(sa));
      req(8'h85, 1'b1, 8'h05, sa);
      req(8'h85, 1'b0, 8'h45, sa);
    end
    req(8'h85, 1'b0, 8'h45, 0);
    $display("Test status A done");
    slow = 1'b1;
    for (int i = 0; i < 6; i++) begin
      v = 8'($random(seed));
      u_host.send(8'h87, 1'b0);
      cfg = v & 8'h1F;
      req(v, 1'b0, 8'h47, cfg);
      req(8'h88, 1'b0, 8'h48, cfg);
    end
    req(8'h87, 1'b1, 8'h07, cfg);
    u_host.send(8'h87, 1'b0);
    req(8'h00, 1'b1, 8'h07, cfg);
    req(8'h88, 1'b1, 8'h08, cfg);
    req(8'h86, 1'b1, 8'h06, sb);
    u_host.send(8'h33, 1'b0);
    req(8'h88, 1'b0, 8'h48, cfg);
    check(8'(u_host.got.size()), 8'h00);
    slow = 1'b0;
    $display("Test configuration done");
    for (int k = 0; k < 4; k++) begin
      pulse_b(4'h8 >> k);
      sb = (k == 0) ? 4 : (k == 1) ? 32 : (k == 2) ? 16 : 8;
      if (k == 2) cfg = 0;
      expect_msg(8'h86, 8'(sb));
      req(8'h86, 1'b0, 8'h46, sb);
    end
    req(8'h88, 1'b0, 8'h48, cfg);
    $display("Test status B done");
    for (int d = 7; d >= 0; d -= 7) begin
      u_host.send(8'h87, 1'b0);
      cfg = d * 4 + 3;
      req(8'(cfg), 1'b0, 8'h47, cfg);
      hi = 3'h1;
      lo = 3'h0;
      repeat (300) @(negedge clk);
      check(8'(gate_high), 8'h01);
      hi = 3'h0;
      lo = 3'h1;
      gap = 0;
      while (gate_low[0] !== 1'b1 && gap < 400) begin
        @(negedge clk);
        gap++;
      end
      ex = (2000 - 250 * d) / 8;
      n_tests++;
      if (gap < ex || gap > ex + 4) begin
        mismatches++;
        $display("Error at %0t: dead gap %0d expected %0d", $time, gap, ex);
      end
      pulse_b(4'h1);
      req(8'h86, 1'b0, 8'h46, 0);
      hi = 3'h1;
      repeat (4) @(negedge clk);
      check({2'h0, gate_high, gate_low}, 8'h00);
      lo = 3'h0;
    end
    repeat (80) @(negedge clk);
    pulse_b(4'h1);
    expect_msg(8'h86, 8'h08);
    req(8'h86, 1'b0, 8'h46, 8);
    $display("Test gate timing done");
    conclude();
  end
endmodule // test_driver_status_config_messages
